/* hw/iox_host.sv */
`include "iox_map.svh"

module iox_host #(
    parameter logic [15:0] QTR_CYC = 16'(`IOX_QTR_CYC),
    parameter logic [15:0] RST_LOW_CYC = 16'(`IOX_RST_LOW_CYC),
    parameter logic [15:0] POST_RST_CYC = 16'(`IOX_POST_RST_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_read,
    input wire logic [7:0] i_cmd_byte,
    input wire logic [7:0] i_cmd_len,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_data,
    input wire logic i_addr_sel,
    input wire logic i_dev_reset,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_dev_rst_n,
    output logic o_addr_sel,
    output logic o_busy,
    output logic o_done,
    output logic o_nack,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_wr_take,
    output logic o_bus_busy
);
    import iox_pkg::*;

    iox_ctl_t r;
    iox_ctl_t n;
    logic [1:0] lvl;
    logic scl_f;
    logic sda_f;
    logic tick;
    logic stall;

    // Filtered, synchronised copies of the bus lines
    for (genvar g = 0; g < 2; g++) begin : g_in
        iox_sync_filt u_filt (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_pin(g == 0 ? i_scl : i_sda),
            .o_level(lvl[g])
        );
    end
    assign scl_f = lvl[0];
    assign sda_f = lvl[1];

    // Bytes that the controller transmits
    function automatic logic is_tx(input iox_role_t role);
        is_tx = (role != RL_DATAR);
    endfunction

    // Address byte with direction bit last
    function automatic logic [7:0] addr_byte(input logic sel,
                                             input logic dir);
        addr_byte = {`IOX_ADDR_HI, sel, dir};
    endfunction

    // Phase timer, held while a released SCL is still low
    always_comb begin
        tick = (r.cnt == 16'h0000);
        stall = !r.scl_oe && !scl_f;
    end

    always_comb begin
        n = r;
        n.rd_valid = 1'b0;
        n.wr_take = 1'b0;
        n.done = 1'b0;
        n.scl_d = scl_f;
        n.sda_d = sda_f;
        // Bus monitor for Start and Stop from any controller
        if (scl_f && r.scl_d && r.sda_d && !sda_f) begin
            n.bus_busy = 1'b1;
        end else if (scl_f && r.scl_d && !r.sda_d && sda_f) begin
            n.bus_busy = 1'b0;
        end
        if (!tick && !stall && !r.want) begin
            n.cnt = r.cnt - 16'h0001;
        end
        case (r.st)
            ST_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (i_dev_reset) begin
                    n.st = ST_DRST;
                    n.busy = 1'b1;
                    n.dev_rst_n = 1'b0;
                    n.cnt = RST_LOW_CYC - 16'h0001;
                end else if (i_cmd_valid && !r.bus_busy && scl_f && sda_f) begin
                    // only an idle bus is claimed
                    n.st = ST_START;
                    n.busy = 1'b1;
                    n.nack = 1'b0;
                    n.rd = i_cmd_read;
                    n.cmd = i_cmd_byte;
                    n.left = i_cmd_len;
                    n.addr_sel = i_addr_sel;
                    n.role = RL_ADDRW;
                    n.ph = 2'd0;
                    n.cnt = QTR_CYC - 16'h0001;
                end
            end
            ST_DRST: begin
                if (tick) begin
                    n.dev_rst_n = 1'b1;
                    n.st = ST_DWAIT;
                    n.cnt = POST_RST_CYC - 16'h0001;
                end
            end
            ST_DWAIT: begin
                if (tick) begin
                    n.st = ST_IDLE;
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end
            ST_START: begin
                // SCL low, release SDA, raise SCL, then pull SDA low
                case (r.ph)
                    2'd0: n.scl_oe = 1'b1;
                    2'd1: n.sda_oe = 1'b0;
                    2'd2: n.scl_oe = 1'b0;
                    default: n.sda_oe = 1'b1;
                endcase
                if (tick && !stall) begin
                    n.ph = r.ph + 2'd1;
                    n.cnt = QTR_CYC - 16'h0001;
                    if (r.ph == 2'd3) begin
                        n.st = ST_BIT;
                        n.bitn = 4'd0;
                        n.shift = addr_byte(r.addr_sel,
                            r.role == RL_ADDRR ? `IOX_DIR_RD : `IOX_DIR_WR);
                    end
                end
            end
            ST_BIT: begin
                case (r.ph)
                    2'd0: n.scl_oe = 1'b1;
                    2'd1: begin
                        // Data changes only while SCL is low
                        if (r.bitn == 4'd8) begin
                            n.sda_oe = !is_tx(r.role)
                                && (r.left > 8'd1);
                        end else begin
                            n.sda_oe = is_tx(r.role) && !r.shift[7];
                        end
                    end
                    default: n.scl_oe = 1'b0;
                endcase
                if (r.want) begin
                    // Stall with SCL low until write data is offered
                    if (i_wr_valid) begin
                        n.want = 1'b0;
                        n.shift = i_wr_data;
                        n.wr_take = 1'b1;
                        n.cnt = QTR_CYC - 16'h0001;
                    end
                end else if (tick && !stall) begin
                    n.ph = r.ph + 2'd1;
                    n.cnt = QTR_CYC - 16'h0001;
                    if (r.ph == 2'd2) begin
                        // Sample in mid high phase
                        if (r.bitn == 4'd8) begin
                            n.ack = sda_f;
                        end else begin
                            n.shift = {r.shift[6:0], sda_f};
                        end
                    end
                    if (r.ph == 2'd3 && r.bitn != 4'd8) begin
                        n.bitn = r.bitn + 4'd1;
                    end else if (r.ph == 2'd3) begin
                        n.bitn = 4'd0;
                        if (is_tx(r.role) && r.ack) begin
                            n.nack = 1'b1;
                            n.st = ST_STOP;
                        end else begin
                            case (r.role)
                                RL_ADDRW: begin
                                    n.role = RL_CMD;
                                    n.shift = r.cmd;
                                end
                                RL_CMD: begin
                                    if (r.rd) begin
                                        n.role = RL_ADDRR;
                                        n.st = ST_START;
                                    end else if (r.left == 8'd0) begin
                                        n.st = ST_STOP;
                                    end else begin
                                        n.role = RL_DATAW;
                                        n.want = 1'b1;
                                    end
                                end
                                RL_DATAW: begin
                                    n.left = r.left - 8'd1;
                                    if (r.left == 8'd1) begin
                                        n.st = ST_STOP;
                                    end else begin
                                        n.want = 1'b1;
                                    end
                                end
                                RL_ADDRR: begin
                                    n.role = RL_DATAR;
                                    if (r.left == 8'd0) begin
                                        n.left = 8'd1;
                                    end
                                end
                                default: begin
                                    n.rd_data = r.shift;
                                    n.rd_valid = 1'b1;
                                    n.left = r.left - 8'd1;
                                    if (r.left <= 8'd1) begin
                                        n.st = ST_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
            end
            ST_STOP: begin
                // SCL low, SDA low, raise SCL, then release SDA
                case (r.ph)
                    2'd0: n.scl_oe = 1'b1;
                    2'd1: n.sda_oe = 1'b1;
                    2'd2: n.scl_oe = 1'b0;
                    default: n.sda_oe = 1'b0;
                endcase
                if (tick && !stall) begin
                    n.ph = r.ph + 2'd1;
                    n.cnt = QTR_CYC - 16'h0001;
                    if (r.ph == 2'd3) begin
                        n.st = ST_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    // Reset also pulses the device reset and waits out its recovery
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            r <= '0;
            r.st <= ST_DRST;
            r.busy <= 1'b1;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Pin and status outputs, all flop driven
    assign o_scl_out = r.pin_lvl;
    assign o_scl_oe = r.scl_oe;
    assign o_sda_out = r.pin_lvl;
    assign o_sda_oe = r.sda_oe;
    assign o_dev_rst_n = r.dev_rst_n;
    assign o_addr_sel = r.addr_sel;
    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_nack = r.nack;
    assign o_rd_data = r.rd_data;
    assign o_rd_valid = r.rd_valid;
    assign o_wr_take = r.wr_take;
    assign o_bus_busy = r.bus_busy;

    // Checks on the link behaviour
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    rst_low_a: assert property (
        $fell(o_dev_rst_n) |-> !o_dev_rst_n ##1 r.st == ST_DRST
            || r.st == ST_DWAIT)
        else $error("device reset pulse malformed");
    post_wait_a: assert property (
        $rose(o_dev_rst_n) |-> (r.st == ST_DWAIT && !o_scl_oe) [*6]
            ##1 r.st == ST_IDLE)
        else $error("start allowed too soon after reset");
    start_cond_a: assert property (
        r.st == ST_START && $rose(o_sda_oe) |-> !o_scl_oe && scl_f)
        else $error("start not made with SCL high");
    addr_byte_a: assert property (
        r.st == ST_BIT && r.role == RL_ADDRW && r.bitn == 4'd0
            && r.ph == 2'd1 |-> r.shift == {`IOX_ADDR_HI, o_addr_sel, 1'b0})
        else $error("address byte wrong");
    addr_hold_a: assert property (
        o_busy && $past(o_busy) && r.st != ST_IDLE |-> $stable(o_addr_sel))
        else $error("address select moved in transaction");
    sda_stable_a: assert property (
        r.st == ST_BIT && !o_scl_oe && $past(!o_scl_oe) |-> $stable(o_sda_oe))
        else $error("SDA changed with SCL high");
    stop_cond_a: assert property (
        r.st == ST_STOP && $fell(o_sda_oe) |-> !o_scl_oe)
        else $error("stop not made with SCL high");
    ack_release_a: assert property (
        r.st == ST_BIT && r.bitn == 4'd8 && r.role != RL_DATAR
            && r.ph[1] |-> !o_sda_oe)
        else $error("SDA held during target ack");
    read_ack_a: assert property (
        r.st == ST_BIT && r.bitn == 4'd8 && r.role == RL_DATAR
            && r.ph == 2'd2 && r.left > 8'd1 |-> o_sda_oe)
        else $error("read byte not acked");
    last_nack_a: assert property (
        r.st == ST_BIT && r.bitn == 4'd8 && r.role == RL_DATAR
            && r.ph == 2'd2 && r.left == 8'd1 |-> !o_sda_oe ##[1:300]
            r.st == ST_STOP)
        else $error("last read byte not ended with nack and stop");
    idle_start_a: assert property (
        $past(r.st) == ST_IDLE && r.st == ST_START |-> $past(!o_bus_busy))
        else $error("transfer started on busy bus");

    wr_done_c: cover property (o_done && !o_nack && !r.rd && r.left == 8'd0);
    rd_done_c: cover property (o_rd_valid ##[1:500] o_done);
    nack_c: cover property ($rose(o_nack));
    dev_rst_c: cover property ($rose(o_dev_rst_n));
endmodule

/* hw/iox_map.svh */
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// Core clock and link timing, in nanoseconds
`define IOX_CLK_NS 100
`define IOX_RST_LOW_NS 4
`define IOX_POST_RST_NS 600
`define IOX_SCL_QTR_NS 5000

// Derived cycle counts, least times rounded up
`define IOX_RST_LOW_CYC ((`IOX_RST_LOW_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)
`define IOX_POST_RST_CYC ((`IOX_POST_RST_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)
`define IOX_QTR_CYC ((`IOX_SCL_QTR_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)

// Target address: upper six bits fixed, bit 0 follows the select strap
`define IOX_ADDR_HI 6'h11
`define IOX_DIR_RD 1'b1
`define IOX_DIR_WR 1'b0

// Input glitch filter length in core cycles
`define IOX_FILT_LEN 3

`endif

/* hw/iox_pkg.sv */
package iox_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DRST  = 3'b001,
        ST_DWAIT = 3'b010,
        ST_START = 3'b011,
        ST_BIT   = 3'b100,
        ST_STOP  = 3'b101
    } iox_state_t;

    // Meaning of the byte on the wire
    typedef enum logic [2:0] {
        RL_ADDRW = 3'b000,
        RL_CMD   = 3'b001,
        RL_DATAW = 3'b010,
        RL_ADDRR = 3'b011,
        RL_DATAR = 3'b100
    } iox_role_t;

    typedef struct packed {
        iox_state_t st;
        iox_role_t role;
        logic [1:0] ph;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [7:0] left;
        logic [7:0] cmd;
        logic rd;
        logic ack;
        logic want;
        logic scl_oe;
        logic sda_oe;
        logic pin_lvl;
        logic dev_rst_n;
        logic addr_sel;
        logic busy;
        logic nack;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_take;
        logic done;
        logic bus_busy;
        logic scl_d;
        logic sda_d;
    } iox_ctl_t;

    typedef struct packed {
        logic [1:0] sync;
        logic [3:0] cnt;
        logic q;
    } iox_filt_t;

endpackage

/* hw/iox_sync_filt.sv */
`include "iox_map.svh"

module iox_sync_filt #(
    parameter logic [3:0] FILT_LEN = 4'(`IOX_FILT_LEN)
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    import iox_pkg::*;

    iox_filt_t r;
    iox_filt_t n;

    // Two-flop synchroniser, then level must persist to be taken
    always_comb begin
        n = r;
        n.sync = {r.sync[0], i_pin};
        if (r.sync[1] == r.q) begin
            n.cnt = 4'h0;
        end else if (r.cnt == FILT_LEN - 4'h1) begin
            n.q = r.sync[1];
            n.cnt = 4'h0;
        end else begin
            n.cnt = r.cnt + 4'h1;
        end
    end

    // Idle bus lines read high
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            r <= '{sync: 2'b11, cnt: 4'h0, q: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign o_level = r.q;
endmodule

/* testbench/iox_dev_model.sv */
module iox_dev_model #(
    parameter logic [5:0] ADDR_HI = 6'h11
) (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_rst_n,
    input wire logic i_addr_sel,
    input wire logic i_stretch,
    input wire logic i_refuse,
    output logic o_scl_oe,
    output logic o_sda_oe,
    output logic [23:0] o_gpio_oe,
    output logic [23:0] o_gpio_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    typedef enum logic [2:0] {S_IDLE, S_ADR, S_CMD, S_WR, S_RD} iox_dst_t;

    iox_dst_t st;
    logic [7:0] regs [16];
    logic [7:0] shreg;
    logic [3:0] bitc;
    logic [3:0] ptr;
    logic ackph;
    logic ctl_nack;

    // Next register inside its group of three
    function automatic logic [3:0] nxt(input logic [3:0] p);
        return {p[3:2], (p[1:0] == 2'h2) ? 2'h0 : p[1:0] + 2'h1};
    endfunction

    // SDA released, outputs high, every pin an input
    task automatic defaults();
        st = S_IDLE;
        o_sda_oe = 1'b0;
        ackph = 1'b0;
        bitc = 4'h0;
        ptr = 4'h0;
        ctl_nack = 1'b0;
        shreg = 8'h00;
        for (int i = 0; i < 16; i++)
            regs[i] = (i[2] == 1'b1) ? 8'hff : 8'h00;
    endtask

    // Power-up state
    initial begin
        o_scl_oe = 1'b0;
        defaults();
    end

    // Reset pin returns registers and bus machine to defaults
    always @(negedge i_rst_n) defaults();

    // Start and repeated Start; SDA edges with SCL low are ignored
    always @(negedge i_sda) begin
        if (i_scl && i_rst_n) begin
            st = S_ADR;
            bitc = 4'h0;
            ackph = 1'b0;
        end
    end

    // Stop ends the transaction
    always @(posedge i_sda) begin
        if (i_scl) begin
            st = S_IDLE;
            o_sda_oe = 1'b0;
        end
    end

    // Sample data bits, or the controller's acknowledge on reads
    always @(posedge i_scl) begin
        if (i_rst_n && st != S_IDLE && !ackph) begin
            shreg = {shreg[6:0], i_sda};
            bitc = bitc + 4'h1;
        end else if (st == S_RD)
            ctl_nack = i_sda;
    end

    // Drive SDA after each falling clock
    always @(negedge i_scl) begin
        if (st == S_IDLE || !i_rst_n) begin
        end else if (ackph) begin
            ackph = 1'b0;
            bitc = 4'h0;
            o_sda_oe = 1'b0;
            if (st == S_RD && ctl_nack)
                st = S_IDLE;
            else if (st == S_RD) begin
                shreg = regs[ptr];
                ptr = nxt(ptr);
                o_sda_oe = !shreg[7];
            end
        end else if (bitc < 4'h8)
            o_sda_oe = (st == S_RD) && !shreg[7];
        else begin
            ackph = 1'b1;
            o_sda_oe = (st != S_RD);
            case (st)
                S_ADR: begin
                    if (shreg[7:1] != {ADDR_HI, i_addr_sel}) begin
                        st = S_IDLE;
                        o_sda_oe = 1'b0;
                    end else begin
                        st = shreg[0] ? S_RD : S_CMD;
                        ctl_nack = 1'b0;
                    end
                end
                S_CMD: begin
                    ptr = shreg[3:0];
                    st = S_WR;
                end
                S_WR: begin
                    if (i_refuse)
                        o_sda_oe = 1'b0;
                    else begin
                        regs[ptr] = shreg;
                        ptr = nxt(ptr);
                    end
                end
                default: ;
            endcase
        end
    end

    // Slow target: hold the clock low a while after each fall
    always @(negedge i_scl) begin
        if (i_stretch) begin
            o_scl_oe = 1'b1;
            #3000;
            o_scl_oe = 1'b0;
        end
    end

    // Drivers only on pins whose config bit is clear
    assign o_gpio_oe = ~{regs[14], regs[13], regs[12]};
    assign o_gpio_pins = {regs[6], regs[5], regs[4]} & o_gpio_oe;
endmodule

/* testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic rd;
        logic sel;
        logic str;
        logic [7:0] cmd;
        logic [7:0] len;
        logic [7:0] d0;
        logic [7:0] d1;
    } iox_row_t;

    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic i_cmd_read = 1'b0;
    logic [7:0] i_cmd_byte = 8'h00;
    logic [7:0] i_cmd_len = 8'h00;
    logic i_wr_valid = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_addr_sel = 1'b0;
    logic i_dev_reset = 1'b0;
    logic stretch = 1'b0;
    logic refuse = 1'b0;
    logic flip = 1'b0;
    logic o_scl_oe, o_sda_oe, o_dev_rst_n, o_addr_sel, o_busy, o_done;
    logic o_nack, o_rd_valid, o_wr_take, o_bus_busy;
    logic [7:0] o_rd_data;
    logic d_scl_oe, d_sda_oe, scl_w, sda_w, strap, scl_o, sda_o;
    logic [23:0] gpio_oe, gpio_pins;
    logic [7:0] rdb [2];
    logic bb_q = 1'b0;
    logic sel_q = 1'b0;
    logic seen_bb = 1'b0;
    int nrd = 0;
    int sel_bad = 0;
    int mismatches = 0;
    int n_compared = 0;
    iox_row_t rows [6] = '{
        '{1'b0, 1'b0, 1'b0, 8'h04, 8'h02, 8'h5a, 8'ha5},
        '{1'b1, 1'b0, 1'b0, 8'h04, 8'h02, 8'h5a, 8'ha5},
        '{1'b0, 1'b1, 1'b1, 8'h06, 8'h02, 8'h3c, 8'hc3},
        '{1'b1, 1'b1, 1'b1, 8'h04, 8'h01, 8'hc3, 8'h00},
        '{1'b0, 1'b0, 1'b0, 8'h0c, 8'h01, 8'h0f, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'h0e, 8'h02, 8'hff, 8'h0f}
    };

    // Open-drain wires with pull-ups
    assign scl_w = ~(o_scl_oe | d_scl_oe);
    assign sda_w = ~(o_sda_oe | d_sda_oe);
    assign strap = o_addr_sel ^ flip;

    always #50 i_core_clk = ~i_core_clk;

    iox_host #(.QTR_CYC(16'h0008)) DUT (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_scl(scl_w),
        .i_sda(sda_w), .i_cmd_valid(i_cmd_valid), .i_cmd_read(i_cmd_read),
        .i_cmd_byte(i_cmd_byte), .i_cmd_len(i_cmd_len),
        .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
        .i_addr_sel(i_addr_sel), .i_dev_reset(i_dev_reset),
        .o_scl_out(scl_o), .o_scl_oe(o_scl_oe), .o_sda_out(sda_o),
        .o_sda_oe(o_sda_oe),
        .o_dev_rst_n(o_dev_rst_n), .o_addr_sel(o_addr_sel), .o_busy(o_busy),
        .o_done(o_done), .o_nack(o_nack), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_wr_take(o_wr_take),
        .o_bus_busy(o_bus_busy)
    );

    iox_dev_model DEV (
        .i_scl(scl_w), .i_sda(sda_w), .i_rst_n(o_dev_rst_n),
        .i_addr_sel(strap), .i_stretch(stretch), .i_refuse(refuse),
        .o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe), .o_gpio_oe(gpio_oe),
        .o_gpio_pins(gpio_pins)
    );

    // Strap must hold while the bus is busy; note bus activity
    always @(negedge i_core_clk) begin
        if (bb_q && o_bus_busy === 1'b1 && o_addr_sel !== sel_q)
            sel_bad++;
        if (o_bus_busy === 1'b1)
            seen_bb = 1'b1;
        bb_q = o_bus_busy;
        sel_q = o_addr_sel;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [3:0] grp_next(input logic [3:0] p);
        return {p[3:2], (p[1:0] == 2'h2) ? 2'h0 : p[1:0] + 2'h1};
    endfunction

    // One whole transaction, data fed and collected by handshake
    task automatic txn(input iox_row_t r);
        int n;
        n = 0;
        nrd = 0;
        @(negedge i_core_clk);
        stretch = r.str;
        i_cmd_valid = 1'b1;
        i_cmd_read = r.rd;
        i_cmd_byte = r.cmd;
        i_cmd_len = r.len;
        i_addr_sel = r.sel;
        i_wr_valid = !r.rd;
        i_wr_data = r.d0;
        while (o_busy !== 1'b1 && n < 50) begin
            @(negedge i_core_clk);
            n++;
        end
        i_cmd_valid = 1'b0;
        while (o_done !== 1'b1 && n < 30000) begin
            @(negedge i_core_clk);
            n++;
            if (o_wr_take === 1'b1)
                i_wr_data = r.d1;
            if (o_rd_valid === 1'b1 && nrd < 2) begin
                rdb[nrd] = o_rd_data;
                nrd++;
            end
        end
        i_wr_valid = 1'b0;
        if (n >= 30000) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic run_row(input iox_row_t r);
        txn(r);
        check("nack", 24'(o_nack), 24'h0);
        if (r.rd) begin
            check("read count", 24'(nrd), 24'(r.len));
            check("read byte 0", 24'(rdb[0]), 24'(r.d0));
            if (r.len == 8'h02)
                check("read byte 1", 24'(rdb[1]), 24'(r.d1));
        end else begin
            check("reg first", 24'(DEV.regs[r.cmd[3:0]]), 24'(r.d0));
            if (r.len == 8'h02)
                check("reg next", 24'(DEV.regs[grp_next(r.cmd[3:0])]),
                      24'(r.d1));
        end
    endtask

    initial begin
        int n;
        repeat (4) @(negedge i_core_clk);
        check("reset outputs", {o_scl_oe, o_sda_oe, o_dev_rst_n, o_busy},
              24'h1);
        repeat (12) @(negedge i_core_clk);
        i_nrst = 1'b1;
        n = 0;
        while (o_dev_rst_n !== 1'b1 && n < 50) begin
            @(negedge i_core_clk);
            n++;
        end
        check("reset pin width", 24'(n >= 1 && n < 50), 24'h1);
        n = 0;
        while (o_busy !== 1'b0 && n < 50) begin
            @(negedge i_core_clk);
            n++;
        end
        check("start hold-off", 24'(n >= 6 && n < 50), 24'h1);
        for (int i = 0; i < 6; i++)
            run_row(rows[i]);
        check("pin enables", gpio_oe, 24'h0000f0);
        check("pin levels", gpio_pins, 24'h0000c0);
        check("drive levels", 24'({scl_o, sda_o}), 24'h0);
        // Wrong strap: device must not answer
        flip = 1'b1;
        txn(iox_row_t'{1'b0, 1'b0, 1'b0, 8'h04, 8'h01, 8'h77, 8'h00});
        flip = 1'b0;
        check("nack on address", 24'(o_nack), 24'h1);
        check("reg untouched", 24'(DEV.regs[4]), 24'h0000c3);
        // Device refuses a data byte
        refuse = 1'b1;
        txn(iox_row_t'{1'b0, 1'b0, 1'b0, 8'h05, 8'h02, 8'h11, 8'h22});
        refuse = 1'b0;
        check("nack on data", 24'(o_nack), 24'h1);
        run_row(iox_row_t'{1'b1, 1'b0, 1'b0, 8'h04, 8'h02, 8'hc3, 8'ha5});
        // Device reset pulse on request
        @(negedge i_core_clk);
        i_dev_reset = 1'b1;
        @(negedge i_core_clk);
        i_dev_reset = 1'b0;
        check("dev reset low", 24'(o_dev_rst_n), 24'h0);
        n = 0;
        while (o_done !== 1'b1 && n < 50) begin
            @(negedge i_core_clk);
            n++;
        end
        check("reset wait done", 24'(n < 50 && n >= 6), 24'h1);
        check("reg default", 24'(DEV.regs[4]), 24'h0000ff);
        check("pins inputs", gpio_oe, 24'h000000);
        check("strap held", 24'(sel_bad), 24'h0);
        check("bus seen busy", 24'(seen_bb), 24'h1);
        check("bus idle", 24'(o_bus_busy), 24'h0);
        finish_test();
    end
endmodule
